//--- verilog/ssio_pkg.sv
// Summary of operation
// [R1] gain bank select high picks banks three/four, low picks one/two.
// [R2] speed modes: analog torque limit input enables analog current limit.
// [R3] indexing mode: start homing input launches the return-to-home sequence.
// [R4] index pause stops the axis and holds; resumes once the input drops; here only once STILL_I is also high.
// [R5] index stop terminates the current index movement.
// [R6] host presents index number on six select inputs; drive decodes it.
// [R7] stop homing halts any homing in progress.
// [R8] start indexing begins the move for the currently selected index.
// [R9] alarm output follows the servo fault condition in every mode.
// [R10] pos/index modes: position done while error within completion width.
// [R11] pos/index modes: position near while error within approach width.
// [R12] speed match while command minus actual speed is within match width; here held low in torque mode.
// [R13] rotation detected while motor speed exceeds rotation detect level.
// [R14] torque limit reached whenever motor torque reaches the torque limit.
// [R15] speed limit reached whenever motor speed reaches the speed limit.
// [R16] brake drive output governs the holding brake, internal or external.
// [R17] absolute position valid only with encoder fitted and data valid.
// [R18] warning output follows the servo warning condition.
// [R19] indexing mode: homing done asserts once homing has completed.
// [R20] in dwell asserts while holding position waiting out the dwell time.
// [R21] six index number outputs show the index in use during indexing.
// [R22] sequence complete asserts when the index movement has finished.
// [R23] select inputs are binary, bit zero least significant, synchronised.
// [R24] all status outputs are re-evaluated and registered every cycle; here only while CE_I is high, and the done flags and index number are held.
package ssio_pkg;

    localparam int DW = 32;
    localparam int IDX_W = 6;
    localparam int DWELL_W = 16;

    // reset values of the registered outputs and state
    localparam logic RST_FLAG = 1'h0;
    localparam logic [IDX_W-1:0] RST_INDEX = 6'h00;
    localparam logic [DWELL_W-1:0] RST_DWELL = 16'h0000;

    // control modes of the drive
    typedef enum logic [2:0] {
        MODE_POS, MODE_SPD, MODE_TSPD, MODE_TRQ, MODE_IDX
    } ssio_mode_t;

    // sequence states
    typedef enum logic [2:0] {
        ST_IDLE, ST_HOMING, ST_RUN, ST_PAUSE, ST_DWELL
    } ssio_state_t;

    // discrete inputs from the host controller
    typedef struct packed {
        logic gain_hi;
        logic atl_en;
        logic home_sens;
        logic home_start;
        logic idx_pause;
        logic idx_stop;
        logic home_stop;
        logic idx_start;
        logic [IDX_W-1:0] idx_sel;
    } ssio_host_in_t;

    // comparison thresholds set by drive parameters
    typedef struct packed {
        logic [DW-1:0] position_done_width;
        logic [DW-1:0] position_near_width;
        logic [DW-1:0] speed_match_width;
        logic [DW-1:0] rotation_detect_level;
        logic [DW-1:0] torque_limit;
        logic [DW-1:0] speed_limit;
    } ssio_cfg_t;

    // live feedback from the control loops
    typedef struct packed {
        logic signed [DW-1:0] pos_err;
        logic signed [DW-1:0] spd_cmd;
        logic signed [DW-1:0] spd_act;
        logic signed [DW-1:0] torque;
    } ssio_fb_t;

endpackage

//--- verilog/ssio_seq_io.sv
module ssio_seq_io
    import ssio_pkg::*;
(
    // clock, reset, enable
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    // host discrete inputs (asynchronous pins)
    input wire ssio_host_in_t HOST_I,
    // drive internal state (control clock domain)
    input wire ssio_mode_t MODE_I,
    input wire ssio_cfg_t CFG_I,
    input wire ssio_fb_t FB_I,
    input wire logic FAULT_I,
    input wire logic WARN_I,
    input wire logic BRAKE_RELEASE_I,
    input wire logic ABS_ENC_I,
    input wire logic ABS_DATA_OK_I,
    input wire logic MOVE_DONE_I,
    input wire logic STILL_I,
    input wire logic [DWELL_W-1:0] DWELL_CYCLES_I,
    // commands to the control loops
    output logic GAIN_BANK_HI_O,
    output logic ANALOG_ILIM_O,
    output logic HOME_RUN_O,
    output logic INDEX_RUN_O,
    output logic DECEL_O,
    // status outputs
    output logic ALARM_O,
    output logic WARNING_O,
    output logic POS_DONE_O,
    output logic POS_NEAR_O,
    output logic SPEED_MATCH_O,
    output logic ROTATING_O,
    output logic TORQUE_LIM_O,
    output logic SPEED_LIM_O,
    output logic BRAKE_DRIVE_O,
    output logic ABS_VALID_O,
    output logic HOME_DONE_O,
    output logic IN_DWELL_O,
    output logic [IDX_W-1:0] INDEX_NUM_O,
    output logic SEQ_DONE_O
);

    // magnitude of a sign-extended value, reused by every comparator
    function automatic logic [DW:0] mag(input logic signed [DW:0] v);
        mag = v[DW] ? (-v) : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release: asserts at once, leaves through two flops
    logic rst_meta_ff, rst_n;
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_ff <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_meta_ff <= 1'h1;
            rst_n <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host pin synchroniser; a third stage gives edge detection
    ssio_host_in_t host_meta_ff, host_ff, host_prev_ff;
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            host_meta_ff <= '0;
            host_ff <= '0;
            host_prev_ff <= '0;
        end else if (CE_I) begin
            host_meta_ff <= HOST_I; // [R23]
            host_ff <= host_meta_ff;
            host_prev_ff <= host_ff;
        end
    end

    logic home_start_rise, idx_start_rise, idx_mode;
    assign home_start_rise = host_ff.home_start && !host_prev_ff.home_start;
    assign idx_start_rise = host_ff.idx_start && !host_prev_ff.idx_start;
    assign idx_mode = (MODE_I == MODE_IDX);

    ////////////////////////////////////////////////////////////////////////
    // comparators on the live feedback
    logic [DW:0] err_mag, spd_mag, trq_mag, dspd_mag;
    logic signed [DW:0] dspd;
    logic pos_mode, spd_mode;
    assign err_mag = mag({FB_I.pos_err[DW-1], FB_I.pos_err});
    assign spd_mag = mag({FB_I.spd_act[DW-1], FB_I.spd_act});
    assign trq_mag = mag({FB_I.torque[DW-1], FB_I.torque});
    assign dspd = {FB_I.spd_cmd[DW-1], FB_I.spd_cmd}
                - {FB_I.spd_act[DW-1], FB_I.spd_act};
    assign dspd_mag = mag(dspd);
    assign pos_mode = (MODE_I == MODE_POS) || idx_mode;
    assign spd_mode = (MODE_I == MODE_SPD) || (MODE_I == MODE_TSPD);

    ////////////////////////////////////////////////////////////////////////
    // sequence state machine for homing and indexing
    ssio_state_t state_ff, nxt_state;
    logic [DWELL_W-1:0] dwell_cnt_ff;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (idx_mode && home_start_rise) begin
                    nxt_state = ST_HOMING; // [R3]
                end else if (idx_mode && idx_start_rise
                             && !host_ff.idx_stop) begin
                    nxt_state = ST_RUN; // [R8]
                end
            end
            ST_HOMING: begin
                // stop outranks the sensor so a halted search never
                // reports done
                if (host_ff.home_stop || !idx_mode) begin
                    nxt_state = ST_IDLE; // [R7]
                end else if (host_ff.home_sens) begin
                    nxt_state = ST_IDLE; // [R19]
                end
            end
            ST_RUN: begin
                if (host_ff.idx_stop || !idx_mode) begin
                    nxt_state = ST_IDLE; // [R5]
                end else if (host_ff.idx_pause) begin
                    nxt_state = ST_PAUSE; // [R4]
                end else if (MOVE_DONE_I) begin
                    nxt_state = ST_DWELL;
                end
            end
            ST_PAUSE: begin
                // resume only once the axis has settled, never mid-ramp
                if (host_ff.idx_stop || !idx_mode) begin
                    nxt_state = ST_IDLE; // [R5]
                end else if (!host_ff.idx_pause && STILL_I) begin
                    nxt_state = ST_RUN; // [R4]
                end
            end
            ST_DWELL: begin
                if (host_ff.idx_stop || !idx_mode) begin
                    nxt_state = ST_IDLE; // [R5]
                end else if (dwell_cnt_ff == RST_DWELL) begin
                    nxt_state = ST_IDLE; // [R22]
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else if (CE_I) begin
            state_ff <= nxt_state;
        end
    end

    // dwell timer, loaded as the move lands
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            dwell_cnt_ff <= RST_DWELL;
        end else if (CE_I) begin
            if (state_ff == ST_RUN && nxt_state == ST_DWELL) begin
                dwell_cnt_ff <= DWELL_CYCLES_I;
            end else if (state_ff == ST_DWELL
                         && dwell_cnt_ff != RST_DWELL) begin
                dwell_cnt_ff <= dwell_cnt_ff - 16'h0001; // [R20]
            end
        end
    end

    // sticky sequence results
    logic done_evt, home_evt;
    assign done_evt = state_ff == ST_DWELL && nxt_state == ST_IDLE
                      && dwell_cnt_ff == RST_DWELL
                      && !host_ff.idx_stop && idx_mode;
    assign home_evt = state_ff == ST_HOMING && nxt_state == ST_IDLE
                      && host_ff.home_sens && !host_ff.home_stop;
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            HOME_DONE_O <= RST_FLAG;
            SEQ_DONE_O <= RST_FLAG;
            INDEX_NUM_O <= RST_INDEX;
        end else if (CE_I) begin
            if (home_evt) begin
                HOME_DONE_O <= 1'h1; // [R19]
            end else if (state_ff == ST_IDLE && nxt_state == ST_HOMING) begin
                HOME_DONE_O <= 1'h0;
            end
            if (done_evt) begin
                SEQ_DONE_O <= 1'h1; // [R22]
            end else if (state_ff == ST_IDLE && nxt_state == ST_RUN) begin
                SEQ_DONE_O <= 1'h0;
            end
            if (state_ff == ST_IDLE && nxt_state == ST_RUN) begin
                INDEX_NUM_O <= host_ff.idx_sel; // [R6] [R21]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered commands and status, refreshed every cycle that CE_I is high
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            GAIN_BANK_HI_O <= RST_FLAG;
            ANALOG_ILIM_O <= RST_FLAG;
            HOME_RUN_O <= RST_FLAG;
            INDEX_RUN_O <= RST_FLAG;
            DECEL_O <= RST_FLAG;
            IN_DWELL_O <= RST_FLAG;
        end else if (CE_I) begin
            GAIN_BANK_HI_O <= host_ff.gain_hi; // [R1]
            ANALOG_ILIM_O <= spd_mode && host_ff.atl_en; // [R2]
            HOME_RUN_O <= (nxt_state == ST_HOMING); // [R3] [R7]
            INDEX_RUN_O <= (nxt_state == ST_RUN); // [R8]
            DECEL_O <= (nxt_state == ST_PAUSE); // [R4]
            IN_DWELL_O <= (nxt_state == ST_DWELL); // [R20]
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ALARM_O <= RST_FLAG;
            WARNING_O <= RST_FLAG;
            POS_DONE_O <= RST_FLAG;
            POS_NEAR_O <= RST_FLAG;
            SPEED_MATCH_O <= RST_FLAG;
            ROTATING_O <= RST_FLAG;
            TORQUE_LIM_O <= RST_FLAG;
            SPEED_LIM_O <= RST_FLAG;
            BRAKE_DRIVE_O <= RST_FLAG;
            ABS_VALID_O <= RST_FLAG;
        end else if (CE_I) begin
            ALARM_O <= FAULT_I; // [R9] [R24]
            WARNING_O <= WARN_I; // [R18]
            POS_DONE_O <= pos_mode
                && err_mag <= {1'h0, CFG_I.position_done_width}; // [R10]
            POS_NEAR_O <= pos_mode
                && err_mag <= {1'h0, CFG_I.position_near_width}; // [R11]
            SPEED_MATCH_O <= MODE_I != MODE_TRQ
                && dspd_mag <= {1'h0, CFG_I.speed_match_width}; // [R12]
            ROTATING_O <= spd_mag
                > {1'h0, CFG_I.rotation_detect_level}; // [R13]
            TORQUE_LIM_O <= trq_mag >= {1'h0, CFG_I.torque_limit}; // [R14]
            SPEED_LIM_O <= spd_mag >= {1'h0, CFG_I.speed_limit}; // [R15]
            // a fault drops the brake at once rather than trust the loop
            BRAKE_DRIVE_O <= BRAKE_RELEASE_I && !FAULT_I; // [R16]
            ABS_VALID_O <= ABS_ENC_I && ABS_DATA_OK_I; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!rst_n);

    property p_gain;
        CE_I && host_ff.gain_hi |=> GAIN_BANK_HI_O;
    endproperty
    a_gain: assert property (p_gain) else $error("gain bank wrong"); // [R1]

    property p_alarm;
        CE_I |=> ALARM_O == $past(FAULT_I);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm lag"); // [R9]

    property p_pos_done;
        CE_I && pos_mode && err_mag <= {1'h0, CFG_I.position_done_width}
            |=> POS_DONE_O;
    endproperty
    a_pos_done: assert property (p_pos_done) else $error("pos done"); // [R10]

    property p_rot;
        CE_I && spd_mag <= {1'h0, CFG_I.rotation_detect_level}
            |=> !ROTATING_O;
    endproperty
    a_rot: assert property (p_rot) else $error("rotation"); // [R13]

    property p_start_idx;
        CE_I && state_ff == ST_IDLE && idx_mode && idx_start_rise
            && !home_start_rise && !host_ff.idx_stop
            |=> INDEX_RUN_O && INDEX_NUM_O == $past(host_ff.idx_sel);
    endproperty
    a_start_idx: assert property (p_start_idx) else $error("start"); // [R8]

    property p_home_stop;
        CE_I && state_ff == ST_HOMING && host_ff.home_stop
            |=> !HOME_RUN_O && state_ff == ST_IDLE && !HOME_DONE_O;
    endproperty
    a_home_stop: assert property (p_home_stop) else $error("hstop"); // [R7]

    property p_idx_stop;
        CE_I && state_ff inside {ST_RUN, ST_PAUSE, ST_DWELL}
            && host_ff.idx_stop |=> state_ff == ST_IDLE && !INDEX_RUN_O;
    endproperty
    a_idx_stop: assert property (p_idx_stop) else $error("istop"); // [R5]

    property p_pause;
        CE_I && state_ff == ST_RUN && idx_mode && host_ff.idx_pause
            && !host_ff.idx_stop |=> DECEL_O ##0 !INDEX_RUN_O;
    endproperty
    a_pause: assert property (p_pause) else $error("pause"); // [R4]

    property p_seq_done;
        CE_I && done_evt |=> SEQ_DONE_O && !IN_DWELL_O;
    endproperty
    a_seq_done: assert property (p_seq_done) else $error("done"); // [R22]

    c_home: cover property (CE_I && home_evt);
    c_done: cover property (CE_I && done_evt);
    c_resume: cover property (state_ff == ST_PAUSE ##1 state_ff == ST_RUN);

endmodule

//--- sim/ssio_host_model.sv
module ssio_host_model
    import ssio_pkg::*;
(
    // control clock, used only for pacing
    input wire logic clk_i,
    // discrete pins towards the drive
    output ssio_host_in_t host_o
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////
    // host pins idle low; every change lands on a falling edge
    initial begin
        host_o = '0;
    end

    // present the index number as a binary pattern, bit zero lowest
    task automatic set_sel(input logic [IDX_W-1:0] sel);
        @(negedge clk_i);
        host_o.idx_sel = sel;
    endtask

    // hold one pin at a level until told otherwise
    task automatic set_pin(input int b, input logic v);
        @(negedge clk_i);
        host_o[b] = v;
    endtask

    // a start pin is held four cycles then released, so the next
    // start is seen as a fresh rising edge after the synchroniser
    task automatic press(input int b);
        set_pin(b, 1'b1);
        repeat (4) @(negedge clk_i);
        host_o[b] = 1'b0;
    endtask
endmodule

//--- sim/testbench.sv
module testbench;
    import ssio_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // bit positions of the host pins inside the packed struct
    localparam int B_GAIN = 13, B_ATL = 12, B_SENS = 11, B_HSTART = 10;
    localparam int B_PAUSE = 9, B_STOP = 8, B_HSTOP = 7, B_ISTART = 6;

    typedef struct {
        ssio_mode_t mode;
        int pe, cmd, act, tq;
        logic [4:0] ctl;
        logic [9:0] exp;
    } ssio_row_t;

    logic clk = 1'b0, rst_n = 1'b0, still = 1'b0, move_done = 1'b0;
    ssio_host_in_t host;
    ssio_mode_t mode = MODE_POS;
    ssio_cfg_t cfg;
    ssio_fb_t fb = '0;
    logic [4:0] ctl = 5'h00;
    logic [9:0] st;
    logic gain_o, ilim_o, hrun, irun, decel, dwell, hdone, sdone;
    logic [IDX_W-1:0] inum;
    logic [5:0] flags;
    logic ce = 1'b1;
    logic [23:0] outs;
    int fails = 0, samples_checked = 0, cnt;
    ssio_row_t rows[5];

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    ssio_host_model ssio_host_model_inst (.clk_i(clk), .host_o(host));

    ssio_seq_io ssio_seq_io_inst (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .HOST_I(host),
        .MODE_I(mode), .CFG_I(cfg), .FB_I(fb), .FAULT_I(ctl[4]),
        .WARN_I(ctl[3]), .BRAKE_RELEASE_I(ctl[2]), .ABS_ENC_I(ctl[1]),
        .ABS_DATA_OK_I(ctl[0]), .MOVE_DONE_I(move_done), .STILL_I(still),
        .DWELL_CYCLES_I(16'h0003), .GAIN_BANK_HI_O(gain_o),
        .ANALOG_ILIM_O(ilim_o), .HOME_RUN_O(hrun), .INDEX_RUN_O(irun),
        .DECEL_O(decel), .ALARM_O(st[9]), .WARNING_O(st[8]),
        .POS_DONE_O(st[7]), .POS_NEAR_O(st[6]), .SPEED_MATCH_O(st[5]),
        .ROTATING_O(st[4]), .TORQUE_LIM_O(st[3]), .SPEED_LIM_O(st[2]),
        .BRAKE_DRIVE_O(st[1]), .ABS_VALID_O(st[0]), .HOME_DONE_O(hdone),
        .IN_DWELL_O(dwell), .INDEX_NUM_O(inum), .SEQ_DONE_O(sdone));

    // flags that the sequence waits poll by position
    assign flags = {irun, decel, dwell, hrun, sdone, hdone};
    // every output at once, for the reset checks
    assign outs = {st, gain_o, ilim_o, hrun, irun, decel, dwell, hdone,
                   sdone, inum};

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bounded wait; a flag that never arrives counts as a mismatch
    task automatic wait_bit(input int b, input logic v);
        cnt = 0;
        while (flags[b] !== v && cnt < 20) begin
            @(negedge clk);
            cnt++;
        end
        check("flag wait", {31'h0000_0000, flags[b]}, {31'h0000_0000, v});
    endtask

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #200000;
        fails++;
        complete_run();
    end

    initial begin
        cfg = {32'h0000_000a, 32'h0000_0064, 32'h0000_0005, 32'h0000_0032,
               32'h0000_00c8, 32'h0000_03e8};
        rows[0] = '{MODE_POS, 10, 100, 95, -200, 5'h0f, 10'h1fb};
        rows[1] = '{MODE_IDX, -11, 0, -50, 199, 5'h16, 10'h240};
        rows[2] = '{MODE_SPD, 0, 1000, 1000, 0, 5'h01, 10'h034};
        rows[3] = '{MODE_TRQ, 0, 0, -1001, 0, 5'h07, 10'h017};
        rows[4] = '{MODE_POS, -100, -5, 0, -300, 5'h00, 10'h068};
        repeat (8) @(negedge clk);
        check("reset outputs", outs, 0);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        // status comparators, one cycle from inputs to outputs
        foreach (rows[i]) begin
            mode = rows[i].mode;
            fb = {rows[i].pe, rows[i].cmd, rows[i].act, rows[i].tq};
            ctl = rows[i].ctl;
            @(negedge clk);
            check("status", st, rows[i].exp);
            check("status", st, rows[i].exp);
        end
        // gain bank pin through the synchroniser
        ssio_host_model_inst.set_pin(B_GAIN, 1'b1);
        repeat (4) @(negedge clk);
        check("gain bank", gain_o, 1);
        ssio_host_model_inst.set_pin(B_GAIN, 1'b0);
        repeat (4) @(negedge clk);
        check("gain bank", gain_o, 0);
        // analog limit only in the two speed modes
        ssio_host_model_inst.set_pin(B_ATL, 1'b1);
        for (int m = 0; m < 5; m++) begin
            mode = ssio_mode_t'(m);
            repeat (4) @(negedge clk);
            check("analog limit", ilim_o, m == 1 || m == 2);
        end
        ssio_host_model_inst.set_pin(B_ATL, 1'b0);
        // a start outside indexing mode is refused
        mode = MODE_POS;
        ssio_host_model_inst.press(B_HSTART);
        repeat (3) @(negedge clk);
        check("home refused", hrun, 0);
        mode = MODE_IDX;
        // index run with pause, dwell and completion
        ssio_host_model_inst.set_sel(6'h2d);
        ssio_host_model_inst.press(B_ISTART);
        wait_bit(5, 1'b1);
        check("index number", inum, 6'h2d);
        check("seq done", sdone, 0);
        ssio_host_model_inst.set_pin(B_PAUSE, 1'b1);
        wait_bit(4, 1'b1);
        check("run in pause", irun, 0);
        still = 1'b1;
        ssio_host_model_inst.set_pin(B_PAUSE, 1'b0);
        wait_bit(5, 1'b1);
        move_done = 1'b1;
        @(negedge clk);
        move_done = 1'b0;
        wait_bit(3, 1'b1);
        cnt = 0;
        while (dwell === 1'b1 && cnt < 50) begin
            cnt++;
            @(negedge clk);
        end
        check("dwell cycles", cnt, 4);
        check("seq done", sdone, 1);
        // second index aborted by stop: done cleared and stays low
        ssio_host_model_inst.set_sel(6'h3f);
        ssio_host_model_inst.press(B_ISTART);
        wait_bit(5, 1'b1);
        check("index number", inum, 6'h3f);
        ssio_host_model_inst.press(B_STOP);
        wait_bit(5, 1'b0);
        check("seq done", sdone, 0);
        // homing halted, then homing to the sensor
        ssio_host_model_inst.press(B_HSTART);
        wait_bit(2, 1'b1);
        ssio_host_model_inst.press(B_HSTOP);
        wait_bit(2, 1'b0);
        check("home done", hdone, 0);
        ssio_host_model_inst.press(B_HSTART);
        wait_bit(2, 1'b1);
        ssio_host_model_inst.set_pin(B_SENS, 1'b1);
        wait_bit(0, 1'b1);
        check("home run", hrun, 0);
        ssio_host_model_inst.set_pin(B_SENS, 1'b0);
        // clock enable low freezes every output
        ce = 1'b0;
        ctl = 5'h18;
        repeat (3) @(negedge clk);
        check("frozen alarm", st[9], 0);
        check("frozen warning", st[8], 0);
        ce = 1'b1;
        @(negedge clk);
        check("alarm after thaw", st[9], 1);
        check("warning after thaw", st[8], 1);
        // reset in mid-run clears the sticky flags at once
        rst_n = 1'b0;
        @(negedge clk);
        check("mid-run reset", outs, 0);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("alarm after reset", st[9], 1);
        check("home done after reset", hdone, 0);
        complete_run();
    end
endmodule
